// *** src/pif_pkg.sv ***
// constants and carrier types of the interrupt flag block
// assumes a single 10 MHz clock and a byte-wide register port from the serial slave
package pif_pkg;

   // ****************************************
   // register offsets
   // ****************************************
   localparam logic [7:0] PIF_ADDR_RESET = 8'h18;
   localparam logic [7:0] PIF_ADDR_TOP   = 8'h19;
   localparam logic [7:0] PIF_ADDR_RSTF  = 8'h1A;
   localparam logic [7:0] PIF_ADDR_REGF  = 8'h1B;
   localparam logic [7:0] PIF_ADDR_LIVE  = 8'h1D;
   localparam logic [7:0] PIF_ADDR_MASK  = 8'h20;

   // ****************************************
   // field positions and reset values
   // ****************************************
   localparam int PIF_TOP_PG_DROP  = 7;
   localparam int PIF_TOP_REG_SUM  = 5;
   localparam int PIF_TOP_EXT_CLK  = 4;
   localparam int PIF_TOP_THERMAL  = 2;
   localparam int PIF_TOP_OVERVOLT = 1;
   localparam int PIF_TOP_MEAS     = 0;
   localparam int PIF_RSTF_EVENT   = 0;
   localparam int PIF_SWRST_BIT    = 0;
   localparam int PIF_REG_ILIM     = 0;
   localparam int PIF_REG_SHORT    = 1;
   localparam int PIF_REG_PG       = 2;
   localparam int PIF_REG_STRIDE   = 4;
   localparam int PIF_LIVE_PG      = 7;
   localparam int PIF_LIVE_CLK_BAD = 4;
   localparam int PIF_LIVE_THERMAL = 2;
   localparam int PIF_LIVE_OVP     = 1;

   localparam logic [7:0] PIF_TOP_W1C    = 8'h97;
   localparam logic [7:0] PIF_REGF_W1C   = 8'h77;
   localparam logic [7:0] PIF_RSTF_W1C   = 8'h01;
   localparam logic [7:0] PIF_MASK_WR    = 8'h95;
   localparam logic [7:0] PIF_FLAG_RESET = 8'h00;
   localparam logic [7:0] PIF_MASK_RESET = 8'h00;

   // ****************************************
   // timing
   // ****************************************
   localparam int PIF_CLK_PERIOD_NS = 100;
   localparam int PIF_SHORT_TIME_NS = 1000000;
   localparam int PIF_SHORT_CYCLES  =
      (PIF_SHORT_TIME_NS + PIF_CLK_PERIOD_NS - 1) / PIF_CLK_PERIOD_NS;

   // ****************************************
   // carriers
   // ****************************************
   typedef struct packed {
      logic       wr;
      logic [7:0] addr;
      logic [7:0] data;
   } pif_req_type;

   typedef struct packed {
      logic       ext_clk_present;
      logic       thermal_warning;
      logic       overvoltage;
      logic       meas_done;
      logic       analog_supply_low;
      logic       power_good_pin;
      logic [1:0] reg_pg_event;
      logic [1:0] reg_below_short;
      logic [1:0] reg_ilim_active;
   } pif_event_type;

endpackage

// *** src/pif_short_timer.sv ***
// short-circuit qualifier for one regulator
// assumes the below-threshold level is synchronous to mclk
`timescale 1ns/1ps
module pif_short_timer
   import pif_pkg::*;
#(
   parameter int SHORT_CYCLES = PIF_SHORT_CYCLES
) (
   input  wire logic mclk,
   input  wire logic reset,
   input  wire logic below,
   output logic      hit
);
   localparam int CW = $clog2(SHORT_CYCLES + 1);

   if (SHORT_CYCLES < 1) begin : g_bad
      $error("pif_short_timer: SHORT_CYCLES must be at least 1");
   end

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic          hit;
   } pif_timer_state_type;

   pif_timer_state_type state_q;
   pif_timer_state_type state_d;

   // ****************************************
   // qualification counter
   // ****************************************
   always_comb begin
      state_d     = state_q;
      state_d.hit = 1'b0;
      if (!below) begin
         state_d.cnt = '0;
      end else if (state_q.cnt != CW'(SHORT_CYCLES)) begin
         state_d.cnt = state_q.cnt + CW'(1);
         // fires once per continuous low period
         if (state_d.cnt == CW'(SHORT_CYCLES)) begin   // [RULE13]
            state_d.hit = 1'b1;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   assign hit = state_q.hit;

   property p_hit_count;
      @(posedge mclk) disable iff (reset)
      state_q.hit |-> (state_q.cnt == CW'(SHORT_CYCLES)) && $past(below);
   endproperty
   a_hit_count: assert property (p_hit_count) else $error("short flag without full count"); // [RULE13]

   property p_count_clears;
      @(posedge mclk) disable iff (reset)
      !below |=> (state_q.cnt == '0) && !state_q.hit;
   endproperty
   a_count_clears: assert property (p_count_clears) else $error("short count not cleared"); // [RULE13]

endmodule

// *** src/pif_flags.sv ***
// latched interrupt flags of the dual regulator controller
// assumes all event inputs and the register port are synchronous to mclk
//
// Notes on behaviour
// RULE1 - top bit 5 is set whenever any regulator flag is pending
// RULE2 - top bit 5 ignores host writes; it clears when regulator flags all clear
// RULE3 - top bit 4 latches when the external clock appears or disappears
// RULE4 - top bit 2 latches when die temperature rises above warning level
// RULE5 - latched thermal flag is separate from the live thermal status bit
// RULE6 - top bit 1 latches when input voltage exceeds the overvoltage level
// RULE7 - an overvoltage event disables regulators and forces both general outputs low
// RULE8 - top bit 0 latches when a new load current result is ready
// RULE9 - top flags stay set until the host writes 1 to them
// RULE10 - reset flag bit 0 latches on analog undervoltage or software reset
// RULE11 - such a reset disables regulators, restores defaults, restarts, keeps reset flag
// RULE12 - regulator power-good events latch bit 6 and bit 2
// RULE13 - output below short threshold over 1 ms latches bit 5 and bit 1
// RULE14 - active current limit latches bit 4 and bit 0
// RULE15 - regulator flags clear by writing 1; bits 7 and 3 read zero
// RULE16 - top bit 7 latches when the power-good pin goes inactive
// RULE17 - a mask bit blocks the interrupt but never the live status
// RULE18 - writing 1 to the software reset bit resets, reloads and self-clears
// RULE19 - writing 0 keeps a flag; an event during a clear keeps it set
`timescale 1ns/1ps
module pif_flags
   import pif_pkg::*;
#(
   parameter int SHORT_CYCLES = PIF_SHORT_CYCLES
) (
   input  wire logic          mclk,
   input  wire logic          reset,
   input  wire pif_req_type   reg_req,
   input  wire pif_event_type events,
   output logic [7:0]         rd_data,
   output logic               irq_n,
   output logic               regulators_off,
   output logic               general_outputs_low,
   output logic               restart,
   output logic               software_reset_bit
);

   if (SHORT_CYCLES < 1) begin : g_bad
      $error("pif_flags: SHORT_CYCLES must be at least 1");
   end

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      logic [7:0]    top;
      logic [7:0]    rstf;
      logic [7:0]    regf;
      logic [7:0]    mask;
      logic [7:0]    rd_data;
      pif_event_type prev;
      logic          irq_n;
      logic          reg_off;
      logic          gpo_low;
      logic          restart;
      logic          swrst;
   } pif_state_type;

   pif_state_type state_q;
   pif_state_type state_d;
   logic [1:0]    short_hit;
   logic          restart_evt;
   logic          sw_req;
   logic          uv_rise;

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic hit_wr(input pif_req_type r, input logic [7:0] a);
      hit_wr = r.wr && (r.addr == a);
   endfunction

   function automatic logic [7:0] w1c(input logic [7:0] cur, input pif_req_type r,
                                      input logic [7:0] a, input logic [7:0] allow);
      w1c = hit_wr(r, a) ? (cur & ~(r.data & allow)) : cur;
   endfunction

   // ****************************************
   // short-circuit qualifiers
   // ****************************************
   for (genvar i = 0; i < 2; i++) begin : g_short
      pif_short_timer #(
         .SHORT_CYCLES (SHORT_CYCLES)
      ) u_timer (
         .mclk  (mclk),
         .reset (reset),
         .below (events.reg_below_short[i]),
         .hit   (short_hit[i])
      );
   end

   assign sw_req      = hit_wr(reg_req, PIF_ADDR_RESET) && reg_req.data[PIF_SWRST_BIT];
   assign uv_rise     = events.analog_supply_low && !state_q.prev.analog_supply_low;
   assign restart_evt = sw_req || uv_rise;

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      state_d         = state_q;
      state_d.prev    = events;
      state_d.reg_off = 1'b0;
      state_d.restart = 1'b0;
      state_d.swrst   = 1'b0;

      if (restart_evt) begin
         // defaults restored, only the reset flag survives
         state_d.top                 = PIF_FLAG_RESET;                   // [RULE11]
         state_d.regf                = PIF_FLAG_RESET;                   // [RULE11]
         state_d.mask                = PIF_MASK_RESET;                   // [RULE11]
         state_d.gpo_low             = 1'b0;
         state_d.rstf                = PIF_FLAG_RESET;
         state_d.rstf[PIF_RSTF_EVENT] = 1'b1;                            // [RULE10]
         state_d.reg_off             = 1'b1;                             // [RULE11]
         state_d.restart             = 1'b1;                             // [RULE11]
         state_d.swrst               = sw_req;                           // [RULE18]
      end else begin
         // clears first so that a same-cycle event wins
         state_d.top  = w1c(state_q.top, reg_req, PIF_ADDR_TOP, PIF_TOP_W1C);    // [RULE9] [RULE19]
         state_d.regf = w1c(state_q.regf, reg_req, PIF_ADDR_REGF, PIF_REGF_W1C); // [RULE15] [RULE19]
         state_d.rstf = w1c(state_q.rstf, reg_req, PIF_ADDR_RSTF, PIF_RSTF_W1C); // [RULE19]
         if (hit_wr(reg_req, PIF_ADDR_MASK)) begin
            state_d.mask = reg_req.data & PIF_MASK_WR;
         end

         if (state_q.prev.power_good_pin && !events.power_good_pin) begin
            state_d.top[PIF_TOP_PG_DROP] = 1'b1;                        // [RULE16]
         end
         if (state_q.prev.ext_clk_present != events.ext_clk_present) begin
            state_d.top[PIF_TOP_EXT_CLK] = 1'b1;                        // [RULE3]
         end
         if (events.thermal_warning && !state_q.prev.thermal_warning) begin
            state_d.top[PIF_TOP_THERMAL] = 1'b1;                        // [RULE4]
         end
         if (events.overvoltage && !state_q.prev.overvoltage) begin
            state_d.top[PIF_TOP_OVERVOLT] = 1'b1;                       // [RULE6]
            state_d.reg_off               = 1'b1;                       // [RULE7]
            state_d.gpo_low               = 1'b1;                       // [RULE7]
         end
         if (events.meas_done) begin
            state_d.top[PIF_TOP_MEAS] = 1'b1;                           // [RULE8]
         end

         for (int i = 0; i < 2; i++) begin
            if (events.reg_pg_event[i]) begin
               state_d.regf[i*PIF_REG_STRIDE + PIF_REG_PG] = 1'b1;      // [RULE12]
            end
            if (short_hit[i]) begin
               state_d.regf[i*PIF_REG_STRIDE + PIF_REG_SHORT] = 1'b1;   // [RULE13]
            end
            if (events.reg_ilim_active[i] && !state_q.prev.reg_ilim_active[i]) begin
               state_d.regf[i*PIF_REG_STRIDE + PIF_REG_ILIM] = 1'b1;    // [RULE14]
            end
         end
      end

      // summary follows the regulator flags, never the host
      state_d.top[PIF_TOP_REG_SUM] = |state_d.regf;                    // [RULE1] [RULE2]

      // masked flags stay visible but do not interrupt
      state_d.irq_n = !(|(state_d.top & ~state_d.mask) || state_d.rstf[PIF_RSTF_EVENT]); // [RULE17]

      case (reg_req.addr)
         PIF_ADDR_TOP:   state_d.rd_data = state_q.top;
         PIF_ADDR_RSTF:  state_d.rd_data = state_q.rstf;
         PIF_ADDR_REGF:  state_d.rd_data = state_q.regf;
         PIF_ADDR_MASK:  state_d.rd_data = state_q.mask;
         PIF_ADDR_LIVE: begin
            // live bits come from the inputs, not the latched flags
            state_d.rd_data                   = 8'h00;
            state_d.rd_data[PIF_LIVE_PG]      = events.power_good_pin;
            state_d.rd_data[PIF_LIVE_CLK_BAD] = !events.ext_clk_present;
            state_d.rd_data[PIF_LIVE_THERMAL] = events.thermal_warning; // [RULE5]
            state_d.rd_data[PIF_LIVE_OVP]     = events.overvoltage;
         end
         PIF_ADDR_RESET: state_d.rd_data = 8'h00;                       // [RULE18]
         default:        state_d.rd_data = 8'h00;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         state_q       <= '0;
         state_q.irq_n <= 1'b1;
      end else begin
         state_q <= state_d;
      end
   end

   assign rd_data             = state_q.rd_data;
   assign irq_n               = state_q.irq_n;
   assign regulators_off      = state_q.reg_off;
   assign general_outputs_low = state_q.gpo_low;
   assign restart             = state_q.restart;
   assign software_reset_bit  = state_q.swrst;

   // ****************************************
   // checks
   // ****************************************
   property p_sum_set;
      @(posedge mclk) disable iff (reset)
      (state_q.regf != 8'h00) |-> state_q.top[PIF_TOP_REG_SUM];
   endproperty
   a_sum_set: assert property (p_sum_set) else $error("summary flag missing"); // [RULE1]

   property p_sum_fall;
      @(posedge mclk) disable iff (reset)
      $fell(state_q.top[PIF_TOP_REG_SUM]) |-> (state_q.regf == 8'h00);
   endproperty
   a_sum_fall: assert property (p_sum_fall) else $error("summary cleared too early"); // [RULE2]

   property p_ext_clk;
      @(posedge mclk) disable iff (reset)
      (events.ext_clk_present != state_q.prev.ext_clk_present) && !restart_evt
         |=> state_q.top[PIF_TOP_EXT_CLK];
   endproperty
   a_ext_clk: assert property (p_ext_clk) else $error("clock change not latched"); // [RULE3]

   property p_thermal;
      @(posedge mclk) disable iff (reset)
      $rose(events.thermal_warning) && !restart_evt |=> state_q.top[PIF_TOP_THERMAL];
   endproperty
   a_thermal: assert property (p_thermal) else $error("thermal warning not latched"); // [RULE4]

   property p_live_thermal;
      @(posedge mclk) disable iff (reset)
      (reg_req.addr == PIF_ADDR_LIVE)
         |=> state_q.rd_data[PIF_LIVE_THERMAL] == $past(events.thermal_warning);
   endproperty
   a_live_thermal: assert property (p_live_thermal) else $error("live thermal wrong"); // [RULE5]

   property p_overvolt;
      @(posedge mclk) disable iff (reset)
      $rose(events.overvoltage) && !restart_evt
         |=> state_q.top[PIF_TOP_OVERVOLT] && state_q.reg_off && state_q.gpo_low;
   endproperty
   a_overvolt: assert property (p_overvolt) else $error("overvoltage not handled"); // [RULE6] [RULE7]

   property p_meas;
      @(posedge mclk) disable iff (reset)
      events.meas_done && !restart_evt |=> state_q.top[PIF_TOP_MEAS];
   endproperty
   a_meas: assert property (p_meas) else $error("measurement flag missing"); // [RULE8]

   property p_hold;
      @(posedge mclk) disable iff (reset)
      state_q.top[PIF_TOP_MEAS] && !restart_evt
         && !(hit_wr(reg_req, PIF_ADDR_TOP) && reg_req.data[PIF_TOP_MEAS])
         |=> state_q.top[PIF_TOP_MEAS];
   endproperty
   a_hold: assert property (p_hold) else $error("flag lost without clear"); // [RULE9] [RULE19]

   property p_uv;
      @(posedge mclk) disable iff (reset)
      uv_rise |=> state_q.rstf[PIF_RSTF_EVENT] && state_q.restart && state_q.reg_off
                  && (state_q.regf == 8'h00) ##1 state_q.rstf[PIF_RSTF_EVENT];
   endproperty
   a_uv: assert property (p_uv) else $error("undervoltage restart wrong"); // [RULE10] [RULE11]

   property p_pg_event;
      @(posedge mclk) disable iff (reset)
      events.reg_pg_event[1] && !restart_evt |=> state_q.regf[PIF_REG_STRIDE + PIF_REG_PG];
   endproperty
   a_pg_event: assert property (p_pg_event) else $error("power-good event lost"); // [RULE12]

   property p_reserved;
      @(posedge mclk) disable iff (reset)
      (state_q.regf & ~PIF_REGF_W1C) == 8'h00;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bit set"); // [RULE15]

   property p_pg_drop;
      @(posedge mclk) disable iff (reset)
      $fell(events.power_good_pin) && !restart_evt |=> state_q.top[PIF_TOP_PG_DROP];
   endproperty
   a_pg_drop: assert property (p_pg_drop) else $error("power-good drop lost"); // [RULE16]

   property p_mask;
      @(posedge mclk) disable iff (reset)
      !restart_evt && (state_q.top != 8'h00) && ((state_q.top & ~state_q.mask) == 8'h00)
         && (state_q.rstf == 8'h00) && !reg_req.wr && (events == state_q.prev)
         && !events.meas_done && (events.reg_pg_event == 2'b00) && (short_hit == 2'b00)
         |=> state_q.irq_n;
   endproperty
   a_mask: assert property (p_mask) else $error("masked flag raised interrupt"); // [RULE17]

   property p_swrst;
      @(posedge mclk) disable iff (reset)
      sw_req |=> state_q.swrst && state_q.rstf[PIF_RSTF_EVENT] ##1 !state_q.swrst;
   endproperty
   a_swrst: assert property (p_swrst) else $error("software reset wrong"); // [RULE18]

endmodule

// *** tb/pif_host.sv ***
// host side of the register port: byte writes and reads
// assumes mclk is the block clock and the host drives on its falling edge
`timescale 1ns/1ps
module pif_host
   import pif_pkg::*;
(
   input  wire logic        mclk,
   output pif_req_type      reg_req,
   input  wire logic [7:0]  rd_data
);
   // ****************************************
   // bus cycles
   // ****************************************
   initial reg_req = '0;

   // one-cycle write strobe; clears by writing ones
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      reg_req = '{wr: 1'b1, addr: a, data: d};
      @(negedge mclk);
      reg_req.wr = 1'b0;
      reg_req.data = ~d;
   endtask

   // data answers one edge after the address is taken
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(negedge mclk);
      reg_req.addr = a;
      @(negedge mclk);
      v = rd_data;
   endtask
endmodule

// *** tb/pif_flags_tb.sv ***
// self-checking bench of the interrupt flag block
// assumes the host model above and a short qualifier of 5 cycles
`timescale 1ns/1ps
module pif_flags_tb
   import pif_pkg::*;
;
   localparam int SHORT = 5;
   logic          mclk;
   logic          reset;
   pif_req_type   reg_req;
   pif_event_type ev;
   logic [7:0]    rd_data;
   logic          irq_n;
   logic          regulators_off;
   logic          general_outputs_low;
   logic          restart;
   logic          software_reset_bit;
   int            miscompares;
   int            tests_run;
   int            n_off;
   int            n_rst;
   int            n_sw;

   pif_flags #(.SHORT_CYCLES(SHORT)) i_pif_flags (
      .mclk(mclk), .reset(reset), .reg_req(reg_req), .events(ev), .rd_data(rd_data),
      .irq_n(irq_n), .regulators_off(regulators_off),
      .general_outputs_low(general_outputs_low), .restart(restart),
      .software_reset_bit(software_reset_bit));
   pif_host i_pif_host (.mclk(mclk), .reg_req(reg_req), .rd_data(rd_data));

   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   // pulse counters
   always @(posedge mclk) begin
      if (regulators_off === 1'b1) n_off++;
      if (restart === 1'b1) n_rst++;
      if (software_reset_bit === 1'b1) n_sw++;
   end

   // ****************************************
   // helpers
   // ****************************************
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] v;
      i_pif_host.rd(a, v);
      chk(v, exp);
   endtask

   task automatic idle(input int n);
      repeat (n) @(negedge mclk);
   endtask

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge mclk);
      miscompares++;
      summarize();
   end

   // ****************************************
   // tests
   // ****************************************
   initial begin
      miscompares = 0; tests_run = 0; n_off = 0; n_rst = 0; n_sw = 0;
      ev = '0;
      reset = 1'b1;
      // count rising edges: the first falling edge of an unset clock is a race
      repeat (4) @(posedge mclk);
      @(negedge mclk);
      reset = 1'b0;
      chk({7'h00, irq_n}, 8'h01);
      rdchk(PIF_ADDR_TOP, 8'h00);
      rdchk(PIF_ADDR_RSTF, 8'h00);
      rdchk(PIF_ADDR_REGF, 8'h00);
      rdchk(8'h30, 8'h00);
      // top events
      @(negedge mclk);
      ev.thermal_warning = 1'b1; ev.overvoltage = 1'b1; ev.meas_done = 1'b1;
      ev.ext_clk_present = 1'b1; ev.power_good_pin = 1'b1;
      @(negedge mclk);
      ev.meas_done = 1'b0; ev.power_good_pin = 1'b0;
      idle(2);
      rdchk(PIF_ADDR_TOP, 8'h97);
      chk({7'h00, general_outputs_low}, 8'h01);
      chk(n_off[7:0], 8'h01);
      rdchk(PIF_ADDR_LIVE, 8'h06);
      chk({7'h00, irq_n}, 8'h00);
      i_pif_host.wr(PIF_ADDR_TOP, 8'h00);
      i_pif_host.wr(PIF_ADDR_TOP, 8'h20);
      rdchk(PIF_ADDR_TOP, 8'h97);
      i_pif_host.wr(PIF_ADDR_TOP, 8'h04);
      rdchk(PIF_ADDR_TOP, 8'h93);
      rdchk(PIF_ADDR_LIVE, 8'h06);
      i_pif_host.wr(PIF_ADDR_TOP, 8'h93);
      rdchk(PIF_ADDR_TOP, 8'h00);
      chk({7'h00, irq_n}, 8'h01);
      // masked thermal flag
      i_pif_host.wr(PIF_ADDR_MASK, 8'h04);
      ev.thermal_warning = 1'b0;
      idle(2);
      ev.thermal_warning = 1'b1;
      idle(2);
      rdchk(PIF_ADDR_TOP, 8'h04);
      chk({7'h00, irq_n}, 8'h01);
      rdchk(PIF_ADDR_LIVE, 8'h06);
      i_pif_host.wr(PIF_ADDR_MASK, 8'h00);
      idle(2);
      chk({7'h00, irq_n}, 8'h00);
      i_pif_host.wr(PIF_ADDR_TOP, 8'h04);
      // event in the clearing cycle
      fork
         i_pif_host.wr(PIF_ADDR_TOP, 8'h01);
         begin
            @(negedge mclk);
            ev.meas_done = 1'b1;
            @(negedge mclk);
            ev.meas_done = 1'b0;
         end
      join
      rdchk(PIF_ADDR_TOP, 8'h01);
      i_pif_host.wr(PIF_ADDR_TOP, 8'h01);
      ev.ext_clk_present = 1'b0;
      idle(2);
      rdchk(PIF_ADDR_TOP, 8'h10);
      rdchk(PIF_ADDR_LIVE, 8'h16);
      i_pif_host.wr(PIF_ADDR_TOP, 8'h10);
      // regulator flags
      @(negedge mclk);
      ev.reg_pg_event = 2'b11; ev.reg_ilim_active = 2'b11;
      @(negedge mclk);
      ev.reg_pg_event = 2'b00;
      idle(2);
      rdchk(PIF_ADDR_REGF, 8'h55);
      rdchk(PIF_ADDR_TOP, 8'h20);
      i_pif_host.wr(PIF_ADDR_REGF, 8'h11);
      rdchk(PIF_ADDR_REGF, 8'h44);
      i_pif_host.wr(PIF_ADDR_TOP, 8'h20);
      rdchk(PIF_ADDR_TOP, 8'h20);
      i_pif_host.wr(PIF_ADDR_REGF, 8'hFF);
      rdchk(PIF_ADDR_REGF, 8'h00);
      rdchk(PIF_ADDR_TOP, 8'h00);
      ev.reg_ilim_active = 2'b00;
      ev.reg_below_short = 2'b11;
      idle(3);
      ev.reg_below_short = 2'b10;
      idle(12);
      rdchk(PIF_ADDR_REGF, 8'h20);
      ev.reg_below_short = 2'b00;
      i_pif_host.wr(PIF_ADDR_REGF, 8'h20);
      // software reset, then undervoltage
      ev.meas_done = 1'b1;
      ev.reg_pg_event = 2'b01;
      @(negedge mclk);
      ev.meas_done = 1'b0;
      ev.reg_pg_event = 2'b00;
      i_pif_host.wr(PIF_ADDR_RESET, 8'h01);
      idle(1);
      rdchk(PIF_ADDR_TOP, 8'h00);
      rdchk(PIF_ADDR_REGF, 8'h00);
      rdchk(PIF_ADDR_RSTF, 8'h01);
      rdchk(PIF_ADDR_RESET, 8'h00);
      chk({7'h00, irq_n}, 8'h00);
      chk({7'h00, general_outputs_low}, 8'h00);
      chk(n_sw[7:0], 8'h01);
      chk(n_rst[7:0], 8'h01);
      chk(n_off[7:0], 8'h02);
      i_pif_host.wr(PIF_ADDR_RSTF, 8'h00);
      rdchk(PIF_ADDR_RSTF, 8'h01);
      i_pif_host.wr(PIF_ADDR_RSTF, 8'h01);
      rdchk(PIF_ADDR_RSTF, 8'h00);
      chk({7'h00, irq_n}, 8'h01);
      ev.analog_supply_low = 1'b1;
      idle(2);
      ev.analog_supply_low = 1'b0;
      rdchk(PIF_ADDR_RSTF, 8'h01);
      chk(n_rst[7:0], 8'h02);
      chk(n_off[7:0], 8'h03);
      chk(n_sw[7:0], 8'h01);
      i_pif_host.wr(PIF_ADDR_RSTF, 8'h01);
      idle(2);
      summarize();
   end
endmodule
